// File: core/can_irq_pkg.sv
package can_irq_pkg;
   // ----------------------------------------
   // Field layouts and codes
   // ----------------------------------------
   localparam int FIFO_CNT_W = 8;
   localparam logic [2:0] THR_FULL = 3'h7;
   localparam logic [2:0] DEPTH_FOUR_MSG = 3'h1;
   localparam logic [1:0] MODE_OPERATE = 2'h0;
   localparam logic [1:0] MODE_RESET = 2'h1;
   localparam logic [1:0] MODE_STANDBY = 2'h2;
   localparam logic [1:0] BOH_AUTO = 2'h0;
   localparam logic [1:0] BOH_STANDBY_AT_START = 2'h1;
   localparam logic [1:0] BOH_STANDBY_ON_REQ = 2'h3;
   localparam int RECESSIVE_RUN = 11;
   localparam int RECOVERY_RUNS = 128;
   localparam int ERR_FLAGS = 7;
   localparam logic [6:0] ERR_FLAGS_RESET = 7'h00;
   localparam logic [3:0] RUN_CNT_RESET = 4'h0;
   localparam logic [7:0] RUNS_CNT_RESET = 8'h00;

   typedef struct packed {
      logic stuffing;
      logic frame_format;
      logic acknowledge;
      logic checksum;
      logic recessive_bit;
      logic dominant_bit;
      logic ack_delim;
   } err_flags_t;

   typedef struct packed {
      logic [1:0] channel_mode_command;
      logic mode_write;
      logic forced_busoff_recovery;
      logic [1:0] busoff_handling_select;
   } channel_ctrl_t;
endpackage

// File: core/fifo_threshold.sv
`timescale 1ns/1ps
`default_nettype none
module fifo_threshold #(
   parameter int CNT_W = 8
) (
   input wire logic [2:0] i_threshold,
   input wire logic [CNT_W-1:0] i_depth,
   input wire logic [CNT_W-1:0] i_count,
   output logic o_reached
);
   import can_irq_pkg::*;
   if (CNT_W < 3) begin : g_cnt_w_check
      $error("fifo_threshold needs CNT_W of at least 3");
   end
   // Compare count*8 against depth*(code+1); full uses code 7 giving depth*8.
   wire [CNT_W+3:0] scaled_count = {1'b0, i_count, 3'h0};
   wire [CNT_W+3:0] scaled_level = (CNT_W + 4)'(i_depth) * (CNT_W + 4)'({1'b0, i_threshold} + 4'h1);
   assign o_reached = (i_count != {CNT_W{1'b0}}) && (scaled_count >= scaled_level);
endmodule
`default_nettype wire

// File: core/can_channel_irq.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - The receive FIFO interrupt fires when occupancy reaches the chosen eighth of its depth or full.
// - The transmit/receive FIFO receive interrupt offers the same eight occupancy conditions.
// - A form error in the ACK delimiter sets its flag and raises the bus-error interrupt.
// - Sending dominant but sampling recessive sets its flag and raises the bus-error interrupt.
// - Sending recessive but sampling dominant sets its flag and raises the bus-error interrupt.
// - A failed CRC on a received frame sets its flag and raises the bus-error interrupt.
// - An acknowledgement error sets its flag and raises the bus-error interrupt.
// - An illegal bit in a fixed-form field sets its flag and raises the bus-error interrupt.
// - A stuffing violation sets its flag and raises the bus-error interrupt.
// - Bus-off recovery is flagged only after 128 runs of 11 recessive bits, never on an early exit.
// - A channel reset command during bus-off ends it without the recovery flag.
// - The forced recovery bit ends bus-off at once without the recovery flag.
// - With handling code 01 the channel enters standby at bus-off start and never flags recovery.
// - With handling code 11 a standby command before recovery ends bus-off without the flag.
module can_channel_irq (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic [2:0] i_rx_fifo_irq_threshold,
   input wire logic [2:0] i_rx_fifo_depth_sel,
   input wire logic [7:0] i_rx_fifo_depth,
   input wire logic [7:0] i_rx_fifo_count,
   input wire logic [2:0] i_txrx_fifo_irq_threshold,
   input wire logic [2:0] i_txrx_fifo_depth_sel,
   input wire logic [7:0] i_txrx_fifo_depth,
   input wire logic [7:0] i_txrx_fifo_count,
   input wire can_irq_pkg::err_flags_t i_err_detect,
   input wire can_irq_pkg::err_flags_t i_err_clear,
   input wire logic i_bus_error_irq_enable,
   input wire logic i_bit_tick,
   input wire logic i_rx_bit,
   input wire logic i_busoff_start,
   input wire can_irq_pkg::channel_ctrl_t i_channel_control_reg,
   input wire logic i_busoff_recovered_clear,
   output logic o_rx_fifo_irq,
   output logic o_txrx_fifo_irq,
   output can_irq_pkg::err_flags_t o_channel_error_flag_reg,
   output logic o_bus_error_irq,
   output logic o_busoff,
   output logic o_standby,
   output logic o_busoff_recovered_flag
);
   import can_irq_pkg::*;

   // ----------------------------------------
   // FIFO thresholds
   // ----------------------------------------
   // Odd eighths of a four-message FIFO are not meaningful; software avoids them.
   logic rx_reached;
   logic txrx_reached;
   fifo_threshold #(.CNT_W(FIFO_CNT_W)) u_rx_thr (
      .i_threshold(i_rx_fifo_irq_threshold),
      .i_depth(i_rx_fifo_depth),
      .i_count(i_rx_fifo_count),
      .o_reached(rx_reached)
   );
   fifo_threshold #(.CNT_W(FIFO_CNT_W)) u_txrx_thr (
      .i_threshold(i_txrx_fifo_irq_threshold),
      .i_depth(i_txrx_fifo_depth),
      .i_count(i_txrx_fifo_count),
      .o_reached(txrx_reached)
   );
   logic rx_reached_q;
   logic txrx_reached_q;
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         rx_reached_q <= 1'b0;
         txrx_reached_q <= 1'b0;
      end else begin
         rx_reached_q <= rx_reached;
         txrx_reached_q <= txrx_reached;
      end
   end
   // A one-cycle pulse when the level is first reached.
   assign o_rx_fifo_irq = rx_reached & ~rx_reached_q;
   assign o_txrx_fifo_irq = txrx_reached & ~txrx_reached_q;

   // ----------------------------------------
   // Bus error flags
   // ----------------------------------------
   err_flags_t err_flags;
   wire [ERR_FLAGS-1:0] next_err_flags = i_err_detect | (err_flags & ~i_err_clear);
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         err_flags <= ERR_FLAGS_RESET;
      end else begin
         err_flags <= next_err_flags;
      end
   end
   assign o_channel_error_flag_reg = err_flags;
   assign o_bus_error_irq = i_bus_error_irq_enable & (|err_flags);

   // ----------------------------------------
   // Bus-off recovery
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_ACTIVE = 3'b001,
      ST_BUSOFF = 3'b010,
      ST_STANDBY = 3'b100
   } bo_state_t;
   bo_state_t state;
   bo_state_t next_state;
   logic [3:0] run_cnt;
   logic [7:0] runs_cnt;
   logic recovered_flag;

   wire in_busoff = (state == ST_BUSOFF);
   wire run_done = i_bit_tick && i_rx_bit && (run_cnt == 4'(RECESSIVE_RUN - 1));
   wire recovery_done = in_busoff && run_done && (runs_cnt == 8'(RECOVERY_RUNS - 1));
   wire ctl_reset = i_channel_control_reg.mode_write
      && (i_channel_control_reg.channel_mode_command == MODE_RESET);
   wire ctl_standby = i_channel_control_reg.mode_write
      && (i_channel_control_reg.channel_mode_command == MODE_STANDBY);
   wire ctl_operate = i_channel_control_reg.mode_write
      && (i_channel_control_reg.channel_mode_command == MODE_OPERATE);
   wire early_exit = ctl_reset
      || i_channel_control_reg.forced_busoff_recovery
      || ((i_channel_control_reg.busoff_handling_select == BOH_STANDBY_ON_REQ)
         && ctl_standby);
   wire standby_at_start = i_channel_control_reg.busoff_handling_select
      == BOH_STANDBY_AT_START;

   always_comb begin
      next_state = state;
      unique case (state)
         ST_ACTIVE: begin
            if (i_busoff_start && standby_at_start) begin
               next_state = ST_STANDBY;
            end else if (i_busoff_start) begin
               next_state = ST_BUSOFF;
            end
         end
         ST_BUSOFF: begin
            if (early_exit && ctl_standby) begin
               next_state = ST_STANDBY;
            end else if (early_exit || recovery_done) begin
               next_state = ST_ACTIVE;
            end
         end
         ST_STANDBY: begin
            if (ctl_operate || ctl_reset) begin
               next_state = ST_ACTIVE;
            end
         end
         default: next_state = ST_ACTIVE;
      endcase
   end

   // Any dominant bit restarts the 11-bit run; the run count survives it.
   wire [3:0] next_run_cnt = (!in_busoff || (i_bit_tick && !i_rx_bit) || run_done)
      ? RUN_CNT_RESET : (i_bit_tick ? run_cnt + 4'h1 : run_cnt);
   wire [7:0] next_runs_cnt = !in_busoff ? RUNS_CNT_RESET
      : (run_done ? runs_cnt + 8'h01 : runs_cnt);
   // Early exit takes priority over a coincident completion, so the flag stays clear.
   wire set_recovered = recovery_done && !early_exit;
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         state <= ST_ACTIVE;
         run_cnt <= RUN_CNT_RESET;
         runs_cnt <= RUNS_CNT_RESET;
         recovered_flag <= 1'b0;
      end else begin
         state <= next_state;
         run_cnt <= next_run_cnt;
         runs_cnt <= next_runs_cnt;
         recovered_flag <= set_recovered || (recovered_flag && !i_busoff_recovered_clear);
      end
   end
   assign o_busoff = in_busoff;
   assign o_standby = (state == ST_STANDBY);
   assign o_busoff_recovered_flag = recovered_flag;

   // ----------------------------------------
   // Recovery check helper
   // ----------------------------------------
   // A plain tally of bit ticks in bus-off, kept apart from the run counters so that
   // the recovery check does not lean on the logic that it guards.
   logic [10:0] busoff_ticks;
   wire busoff_ticks_full = (busoff_ticks == 11'h7ff);
   wire [10:0] next_busoff_ticks = !in_busoff ? 11'h000
      : ((i_bit_tick && !busoff_ticks_full) ? busoff_ticks + 11'h001 : busoff_ticks);
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         busoff_ticks <= 11'h000;
      end else begin
         busoff_ticks <= next_busoff_ticks;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_rx_thr_edge: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      o_rx_fifo_irq && $past(i_rst_b) |-> rx_reached && !$past(rx_reached))
      else $error("rx fifo irq without a fresh threshold");
   a_txrx_thr_edge: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      txrx_reached && !$past(txrx_reached) && $past(i_rst_b) |-> o_txrx_fifo_irq)
      else $error("txrx fifo irq missing");
   a_err_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      i_err_detect.ack_delim |=> o_channel_error_flag_reg.ack_delim)
      else $error("ack delimiter flag not set");
   a_err_irq: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (|i_err_detect) && i_bus_error_irq_enable |=> o_bus_error_irq || !i_bus_error_irq_enable)
      else $error("bus error irq not raised");
   a_err_sticky: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      o_channel_error_flag_reg.stuffing && !i_err_clear.stuffing
      |=> o_channel_error_flag_reg.stuffing)
      else $error("stuffing flag lost without clear");
   a_early_no_flag: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      in_busoff && i_channel_control_reg.forced_busoff_recovery
      |=> !o_busoff && !$rose(o_busoff_recovered_flag))
      else $error("forced recovery misbehaved");
   a_start_standby: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      !in_busoff && !o_standby && i_busoff_start && standby_at_start
      |=> o_standby && !o_busoff)
      else $error("standby at bus-off start missing");
   a_recover_flag: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      $rose(o_busoff_recovered_flag)
      |-> $past(in_busoff) && $past(runs_cnt) == 8'(RECOVERY_RUNS - 1))
      else $error("recovery flag without 128 runs");

   // ----------------------------------------
   // FIFO level checks
   // ----------------------------------------
   a_rx_full_level: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      i_rx_fifo_irq_threshold == THR_FULL && i_rx_fifo_count == i_rx_fifo_depth
      && i_rx_fifo_count != 8'h00 |-> rx_reached)
      else $error("rx fifo full level not reached");
   a_txrx_full_level: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      i_txrx_fifo_irq_threshold == THR_FULL && i_txrx_fifo_count == i_txrx_fifo_depth
      && i_txrx_fifo_count != 8'h00 |-> txrx_reached)
      else $error("txrx fifo full level not reached");
   a_rx_empty_quiet: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      i_rx_fifo_count == 8'h00 |-> !o_rx_fifo_irq)
      else $error("rx fifo irq while empty");
   a_txrx_empty_quiet: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      i_txrx_fifo_count == 8'h00 |-> !o_txrx_fifo_irq)
      else $error("txrx fifo irq while empty");

   // ----------------------------------------
   // Error flag checks
   // ----------------------------------------
   a_dom_bit_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      i_err_detect.dominant_bit |=> o_channel_error_flag_reg.dominant_bit)
      else $error("dominant bit flag not set");
   a_rec_bit_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      i_err_detect.recessive_bit |=> o_channel_error_flag_reg.recessive_bit)
      else $error("recessive bit flag not set");
   a_crc_flag_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      i_err_detect.checksum |=> o_channel_error_flag_reg.checksum)
      else $error("checksum flag not set");
   a_ack_flag_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      i_err_detect.acknowledge |=> o_channel_error_flag_reg.acknowledge)
      else $error("acknowledge flag not set");
   a_form_flag_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      i_err_detect.frame_format |=> o_channel_error_flag_reg.frame_format)
      else $error("frame format flag not set");
   a_stuff_flag_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      i_err_detect.stuffing |=> o_channel_error_flag_reg.stuffing)
      else $error("stuffing flag not set");
   a_set_beats_clear: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      i_err_detect.checksum && i_err_clear.checksum |=> o_channel_error_flag_reg.checksum)
      else $error("clear beat a coincident detection");
   a_clear_drops: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      i_err_clear.ack_delim && !i_err_detect.ack_delim
      |=> !o_channel_error_flag_reg.ack_delim)
      else $error("ack delimiter flag not cleared");

   // ----------------------------------------
   // Bus-off checks
   // ----------------------------------------
   // The reset and standby-request exit checks are built from the same steps, so a new path reuses the shape.
   sequence s_busoff_entry;
      !in_busoff && !o_standby && i_busoff_start && !standby_at_start;
   endsequence
   sequence s_left_busoff;
      !o_busoff && !$rose(o_busoff_recovered_flag);
   endsequence
   sequence s_reset_in_busoff;
      in_busoff && ctl_reset;
   endsequence
   sequence s_standby_req_in_busoff;
      in_busoff && ctl_standby
      && (i_channel_control_reg.busoff_handling_select == BOH_STANDBY_ON_REQ);
   endsequence
   a_busoff_entry: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      s_busoff_entry |=> o_busoff && !o_standby)
      else $error("bus-off not entered");
   a_reset_exit: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      s_reset_in_busoff |=> s_left_busoff ##0 !o_standby)
      else $error("channel reset did not end bus-off cleanly");
   a_standby_req: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      s_standby_req_in_busoff |=> s_left_busoff ##0 o_standby)
      else $error("standby request did not end bus-off cleanly");
   a_standby_no_flag: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      o_standby |-> !$rose(o_busoff_recovered_flag))
      else $error("recovery flag raised in standby");
   a_recover_done: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      recovery_done && !early_exit |=> !o_busoff && o_busoff_recovered_flag)
      else $error("completed recovery not flagged");
   a_recover_count: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      $rose(o_busoff_recovered_flag)
      |-> $past(busoff_ticks) >= 11'(RECESSIVE_RUN * RECOVERY_RUNS - 1))
      else $error("recovery flag after too few bit ticks");
   a_recover_sticky: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      o_busoff_recovered_flag && !i_busoff_recovered_clear |=> o_busoff_recovered_flag)
      else $error("recovery flag lost without clear");
   a_run_bound: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      run_cnt < 4'(RECESSIVE_RUN))
      else $error("recessive run counter overran");
endmodule
`default_nettype wire

// File: test/can_bus_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Remote nodes on the bus
// ----------------------------------------
// The bit tick stands still between bursts, and the idle bus reads recessive.
module can_bus_partner (
   input wire logic i_mclk,
   output logic o_bit_tick,
   output logic o_rx_bit
);
   initial begin
      o_bit_tick = 1'b0;
      o_rx_bit = 1'b1;
   end
   task automatic send_bits(input int n, input logic val);
      for (int k = 0; k < n; k++) begin
         @(posedge i_mclk);
         o_bit_tick <= 1'b1;
         o_rx_bit <= val;
         @(posedge i_mclk);
         o_bit_tick <= 1'b0;
         o_rx_bit <= 1'b1;
      end
   endtask
endmodule
`default_nettype wire

// File: test/can_channel_irq_and_error_flags_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module can_channel_irq_and_error_flags_tb_top;
   import can_irq_pkg::*;
   logic mclk = 1'b0, rst_b = 1'b0, irq_en = 1'b0, bo_start = 1'b0, bo_clr = 1'b0;
   logic [2:0] thr = 3'h0, dsel = 3'h0;
   logic [7:0] depth = 8'h00, cnt = 8'h00;
   err_flags_t det = '0, clr = '0, flags;
   channel_ctrl_t ctl = '0;
   logic rx_irq, trx_irq, bus_irq, busoff, standby, rec_flag, tick, rxb;
   int err_total = 0, checked = 0, cyc = 0, n, lim;

   always #2 mclk = ~mclk;

   can_bus_partner BUS (.i_mclk(mclk), .o_bit_tick(tick), .o_rx_bit(rxb));
   can_channel_irq DUT (.i_mclk(mclk), .i_rst_b(rst_b),
      .i_rx_fifo_irq_threshold(thr), .i_rx_fifo_depth_sel(dsel), .i_rx_fifo_depth(depth),
      .i_rx_fifo_count(cnt), .i_txrx_fifo_irq_threshold(thr), .i_txrx_fifo_depth_sel(dsel),
      .i_txrx_fifo_depth(depth), .i_txrx_fifo_count(cnt), .i_err_detect(det),
      .i_err_clear(clr), .i_bus_error_irq_enable(irq_en), .i_bit_tick(tick), .i_rx_bit(rxb),
      .i_busoff_start(bo_start), .i_channel_control_reg(ctl), .i_busoff_recovered_clear(bo_clr),
      .o_rx_fifo_irq(rx_irq), .o_txrx_fifo_irq(trx_irq), .o_channel_error_flag_reg(flags),
      .o_bus_error_irq(bus_irq), .o_busoff(busoff), .o_standby(standby),
      .o_busoff_recovered_flag(rec_flag));

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // The whole run needs about 3340 cycles; the ceiling leaves ample margin.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 8000) begin
         err_total++;
         report_and_stop();
      end
   end

   task automatic bo_begin(input logic [1:0] boh);
      @(posedge mclk);
      ctl.busoff_handling_select <= boh;
      bo_start <= 1'b1;
      @(posedge mclk);
      bo_start <= 1'b0;
      #1;
   endtask

   task automatic ctl_pulse(input logic [1:0] cmd, input logic wr, input logic frc);
      @(posedge mclk);
      ctl.channel_mode_command <= cmd;
      ctl.mode_write <= wr;
      ctl.forced_busoff_recovery <= frc;
      @(posedge mclk);
      ctl.mode_write <= 1'b0;
      ctl.forced_busoff_recovery <= 1'b0;
      #1;
   endtask

   initial begin
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      // ----------------------------------------
      // Fill thresholds, odd eighths only on deep FIFOs
      // ----------------------------------------
      for (int c = 0; c < 12; c++) begin
         n = (c < 8) ? c : 2 * (c - 8) + 1;
         lim = (c < 8) ? 16 : 4;
         @(posedge mclk);
         thr <= n[2:0];
         depth <= lim[7:0];
         dsel <= (c < 8) ? 3'h4 : DEPTH_FOUR_MSG;
         cnt <= 8'h00;
         for (int m = 1; m <= lim; m++) begin
            @(posedge mclk);
            cnt <= m[7:0];
            #1;
            chk("rx_fifo_irq", m == lim * (n + 1) / 8, rx_irq);
            chk("txrx_fifo_irq", m == lim * (n + 1) / 8, trx_irq);
         end
      end
      $display("fifo threshold test done");
      // ----------------------------------------
      // Sticky error flags and the bus-error interrupt
      // ----------------------------------------
      for (int b = 0; b < 7; b++) begin
         @(posedge mclk);
         irq_en <= 1'b1;
         det <= err_flags_t'(7'h01 << b);
         @(posedge mclk);
         det <= '0;
         repeat (4) @(posedge mclk);
         #1;
         chk("error_flags", 8'h01 << b, {1'b0, flags});
         chk("bus_error_irq", 8'h01, bus_irq);
         @(posedge mclk);
         irq_en <= 1'b0;
         #1;
         chk("bus_error_irq", 8'h00, bus_irq);
         @(posedge mclk);
         irq_en <= 1'b1;
         clr <= err_flags_t'(7'h01 << b);
         @(posedge mclk);
         clr <= '0;
         #1;
         chk("error_flags", 8'h00, {1'b0, flags});
         chk("bus_error_irq", 8'h00, bus_irq);
      end
      // A detection and a clear of the same flag in one cycle leave the flag set.
      @(posedge mclk);
      det <= '1;
      clr <= '1;
      @(posedge mclk);
      det <= '0;
      #1;
      chk("error_flags", 8'h7f, {1'b0, flags});
      chk("bus_error_irq", 8'h01, bus_irq);
      @(posedge mclk);
      clr <= '0;
      #1;
      chk("error_flags", 8'h00, {1'b0, flags});
      $display("error flag test done");
      // ----------------------------------------
      // Full recovery, with one broken run first
      // ----------------------------------------
      bo_begin(BOH_AUTO);
      chk("busoff", 8'h01, busoff);
      BUS.send_bits(6, 1'b1);
      BUS.send_bits(1, 1'b0);
      BUS.send_bits(RECESSIVE_RUN * RECOVERY_RUNS - 1, 1'b1);
      #1;
      chk("busoff", 8'h01, busoff);
      chk("recovered", 8'h00, rec_flag);
      BUS.send_bits(1, 1'b1);
      #1;
      chk("busoff", 8'h00, busoff);
      chk("recovered", 8'h01, rec_flag);
      @(posedge mclk);
      bo_clr <= 1'b1;
      @(posedge mclk);
      bo_clr <= 1'b0;
      #1;
      chk("recovered", 8'h00, rec_flag);
      $display("recovery test done");
      // ----------------------------------------
      // Early exits: reset, forced, standby at start, standby on request
      // ----------------------------------------
      for (int e = 0; e < 4; e++) begin
         bo_begin(e == 2 ? BOH_STANDBY_AT_START : e == 3 ? BOH_STANDBY_ON_REQ : BOH_AUTO);
         chk("busoff", e != 2, busoff);
         chk("standby", e == 2, standby);
         BUS.send_bits(30, 1'b1);
         if (e == 0) ctl_pulse(MODE_RESET, 1'b1, 1'b0);
         if (e == 1) ctl_pulse(MODE_OPERATE, 1'b0, 1'b1);
         if (e == 3) ctl_pulse(MODE_STANDBY, 1'b1, 1'b0);
         chk("busoff", 8'h00, busoff);
         chk("standby", e >= 2, standby);
         chk("recovered", 8'h00, rec_flag);
         ctl_pulse(e == 2 ? MODE_RESET : MODE_OPERATE, 1'b1, 1'b0);
         chk("standby", 8'h00, standby);
      end
      $display("early exit test done");
      report_and_stop();
   end
endmodule
`default_nettype wire
